// ==== core/monitor_pkg.sv ====
package monitor_pkg;

  // ****************************************************************
  // Register offsets (word addresses on the serial link)
  // ****************************************************************
  localparam logic [5:0] OFS_DIE_TEMPERATURE  = 6'h06;
  localparam logic [5:0] OFS_CURRENT_RESULT   = 6'h07;
  localparam logic [5:0] OFS_POWER_RESULT     = 6'h08;
  localparam logic [5:0] OFS_ENERGY_ACC       = 6'h09;
  localparam logic [5:0] OFS_CHARGE_ACC       = 6'h0a;
  localparam logic [5:0] OFS_FAULT_FLAGS      = 6'h0b;
  localparam logic [5:0] OFS_SHUNT_HIGH       = 6'h0c;

  // ****************************************************************
  // Register widths in bits
  // ****************************************************************
  localparam int W_TEMP    = 16;
  localparam int W_CURRENT = 24;
  localparam int W_POWER   = 24;
  localparam int W_ACC     = 40;
  localparam int W_FLAGS   = 16;
  localparam int W_RESULT  = 20;

  // ****************************************************************
  // Fault flag register bit positions
  // ****************************************************************
  localparam int B_HOLD_SEL    = 15;
  localparam int B_READY_ALERT = 14;
  localparam int B_CMP_AVG     = 13;
  localparam int B_POLARITY    = 12;
  localparam int B_ENERGY_OF   = 11;
  localparam int B_CHARGE_OF   = 10;
  localparam int B_MATH_OF     = 9;
  localparam int B_TEMP_OL     = 7;
  localparam int B_SHUNT_OL    = 6;
  localparam int B_SHUNT_UL    = 5;
  localparam int B_BUS_OL      = 4;
  localparam int B_BUS_UL      = 3;
  localparam int B_POWER_OL    = 2;
  localparam int B_CONV_DONE   = 1;
  localparam int B_TRIM_OK     = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] RST_FAULT_FLAGS = 16'h0001;
  localparam logic [15:0] RST_SHUNT_HIGH  = 16'h7fff;

  // ****************************************************************
  // Serial frame layout, counted in link clock edges
  // ****************************************************************
  localparam logic [5:0] CMD_LAST_BIT   = 6'h07;
  localparam logic [5:0] WR_LAST_BIT    = 6'h17;
  localparam logic [5:0] RD_LOAD_EDGE   = 6'h10;

  // Core clock period
  localparam int CORE_PERIOD_NS = 25;

endpackage

// ==== core/link_if.sv ====
`timescale 1ns/1ps
// Request and read data between the link end and the register core
interface link_if;
  logic        req_tgl;    // Toggles once per taken request
  logic [5:0]  req_addr;   // Register offset
  logic        req_write;  // 1 write, 0 read
  logic [15:0] req_wdata;  // Write data
  logic [39:0] rd_data;    // Read data, left aligned
  logic        link_rst;   // Reset of the link end, from core domain

  modport link (output req_tgl, output req_addr, output req_write,
                output req_wdata, input rd_data, input link_rst);
  modport core (input req_tgl, input req_addr, input req_write,
                input req_wdata, output rd_data, output link_rst);
endinterface

// ==== core/sync_2ff.sv ====
`timescale 1ns/1ps
// Two flop synchroniser for a level
module sync_2ff
  import monitor_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Level in and out
  input  wire logic d_in,
  output logic      q_out
);

  logic meta_r;  // First stage, read only by second stage

  // ****************************************************************
  // Two stages
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_r <= 1'b0;
      q_out  <= 1'b0;
    end
    else
    begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule

// ==== core/serial_link.sv ====
`timescale 1ns/1ps
// Link end, runs on the serial clock of the host
module serial_link
  import monitor_pkg::*;
(
  // Serial pins
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  output logic      miso,
  output logic      miso_oe,
  // Core side
  link_if.link      lnk
);

  logic [5:0]  bit_cnt_r;   // Rising edges seen in this frame
  logic [22:0] shift_r;     // Received bits
  logic        is_read_r;   // Frame is a read
  logic [38:0] tx_r;        // Remaining read bits
  logic        tgl_r;       // Request toggle
  wire  [7:0]  cmd_byte = {shift_r[6:0], mosi};

  // ****************************************************************
  // Receive side, frame state cleared while select is high
  // ****************************************************************
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_cnt_r <= 6'h00;
      shift_r   <= 23'h00_0000;
      is_read_r <= 1'b0;
    end
    else
    begin
      // Saturate so that long reads do not wrap
      if (bit_cnt_r != 6'h3f)
        bit_cnt_r <= bit_cnt_r + 6'h01;
      shift_r <= {shift_r[21:0], mosi};
      if (bit_cnt_r == CMD_LAST_BIT)
        is_read_r <= cmd_byte[0];
    end
  end

  // ****************************************************************
  // Request fields, live across frames until the next request
  // ****************************************************************
  always_ff @(posedge sclk or posedge lnk.link_rst)
  begin
    if (lnk.link_rst)
    begin
      tgl_r         <= 1'b0;
      lnk.req_addr  <= 6'h00;
      lnk.req_write <= 1'b0;
      lnk.req_wdata <= 16'h0000;
    end
    else if (!cs_n && bit_cnt_r == CMD_LAST_BIT && cmd_byte[0])
    begin
      // Read is fetched during the dummy byte that follows
      lnk.req_addr  <= cmd_byte[7:2];
      lnk.req_write <= 1'b0;
      tgl_r         <= ~tgl_r;
    end
    else if (!cs_n && bit_cnt_r == WR_LAST_BIT && !is_read_r)
    begin
      // Short write frames are dropped, never half applied
      lnk.req_addr  <= shift_r[22:17];
      lnk.req_write <= 1'b1;
      lnk.req_wdata <= {shift_r[14:0], mosi};
      tgl_r         <= ~tgl_r;
    end
  end

  assign lnk.req_tgl = tgl_r;

  // ****************************************************************
  // Transmit side, changes on falling edges
  // ****************************************************************
  // Read data is quasi static: the core settles it within a few of
  // its cycles, far inside the eight link clocks of the dummy byte.
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      miso    <= 1'b0;
      miso_oe <= 1'b0;
      tx_r    <= 39'h00_0000_0000;
    end
    else
    begin
      miso_oe <= 1'b1;
      if (is_read_r && bit_cnt_r == RD_LOAD_EDGE)
      begin
        miso <= lnk.rd_data[39];
        tx_r <= lnk.rd_data[38:0];
      end
      else
      begin
        miso <= tx_r[38];
        tx_r <= {tx_r[37:0], 1'b0};
      end
    end
  end

endmodule

// ==== core/monitor_regs.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Temperature: 16-bit signed, whole register
// [R2] Current: 20-bit signed in 23:4, low zero
// [R3] Power: 24-bit unsigned, full width
// [R4] Energy: 40-bit unsigned accumulator register
// [R5] Charge: 40-bit signed accumulator register
// [R6] Transparent hold: flags follow fault condition
// [R7] Latched hold: flags stay until register read
// [R8] Ready enable routes conversion done to alert
// [R9] Compare on raw or averaged results
// [R10] Polarity bit selects alert active level
// [R11] Accumulator overflow flags clear on accumulator read
// [R12] Arithmetic overflow clears on trigger or clear
// [R13] Temperature over-limit flag
// [R14] Shunt over-limit flag
// [R15] Shunt under-limit flag
// [R16] Bus over-limit flag
// [R17] Bus under-limit flag
// [R18] Power over-limit flag
// [R19] Conversion done flag, cleared by read/trigger
// [R20] Trim memory status resets one, checksum clears
// [R21] Negative shunt high threshold trips at zero
// [R22] Host sets high threshold less negative
// [R23] Results update after averaging completes
// [R24] Shunt high threshold: 16-bit signed register
// [R25] Alert from any limit or routed done
// [R26] One comparison per updated result; code compares on each sample_valid, or on each avg_done when cmp_avg is set
module monitor_regs
  import monitor_pkg::*;
(
  // Core clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // Serial link pins
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                mosi,
  output logic                     miso,
  output logic                     miso_oe,
  // Open drain alert pin
  output logic                     alert_o,
  output logic                     alert_oe,
  // Converter results and strobes
  input  wire logic                sample_valid,
  input  wire logic                avg_done,
  input  wire logic [2:0]          averaging_count,
  input  wire logic [W_TEMP-1:0]   die_temperature_value,
  input  wire logic [W_RESULT-1:0] current_value,
  input  wire logic [W_POWER-1:0]  power_value,
  input  wire logic [W_RESULT-1:0] shunt_value,
  input  wire logic [W_RESULT-1:0] bus_value,
  input  wire logic [W_ACC-1:0]    energy_value,
  input  wire logic [W_ACC-1:0]    charge_value,
  // Thresholds held elsewhere
  input  wire logic [15:0]         shunt_low_threshold,
  input  wire logic [14:0]         bus_high_threshold,
  input  wire logic [14:0]         bus_low_threshold,
  input  wire logic [15:0]         temp_high_threshold,
  input  wire logic [15:0]         power_high_threshold,
  // Event strobes
  input  wire logic                energy_ovf_evt,
  input  wire logic                charge_ovf_evt,
  input  wire logic                math_ovf_evt,
  input  wire logic                conversion_trigger,
  input  wire logic                accumulator_clear_command,
  input  wire logic                trim_checksum_err
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Signed greater than, used by every over and under comparison except power
  function automatic logic sgt(input logic [15:0] a,
                               input logic [15:0] b);
    sgt = $signed(a) > $signed(b);
  endfunction

  // Left align a value of given width into the read word
  function automatic logic [39:0] align(input logic [39:0] v,
                                        input int w);
    align = v << (40 - w);
  endfunction

  // ****************************************************************
  // Link end and crossing
  // ****************************************************************
  link_if lnk ();

  logic        req_s;       // Synchronised request toggle
  logic        req_seen_r;  // Last toggle served
  logic        link_rst_r;  // Reset handed to link domain
  logic [39:0] rd_data_r;   // Read word held for link

  serial_link u_link (
    .sclk    (sclk),
    .cs_n    (cs_n),
    .mosi    (mosi),
    .miso    (miso),
    .miso_oe (miso_oe),
    .lnk     (lnk.link)
  );

  sync_2ff u_req_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d_in     (lnk.req_tgl),
    .q_out    (req_s)
  );

  assign lnk.rd_data  = rd_data_r;
  assign lnk.link_rst = link_rst_r;

  // Request decode
  wire req_now   = req_s ^ req_seen_r;
  wire wr_now    = req_now && lnk.req_write;
  wire rd_now    = req_now && !lnk.req_write;
  wire rd_flags  = rd_now && lnk.req_addr == OFS_FAULT_FLAGS;
  wire rd_energy = rd_now && lnk.req_addr == OFS_ENERGY_ACC;
  wire rd_charge = rd_now && lnk.req_addr == OFS_CHARGE_ACC;
  wire wr_flags  = wr_now && lnk.req_addr == OFS_FAULT_FLAGS;
  wire wr_shunt  = wr_now && lnk.req_addr == OFS_SHUNT_HIGH;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [W_TEMP-1:0]   temp_r;       // Die temperature result
  logic [W_RESULT-1:0] current_r;    // Current result
  logic [W_POWER-1:0]  power_r;      // Power result
  logic [W_ACC-1:0]    energy_r;     // Energy accumulator copy
  logic [W_ACC-1:0]    charge_r;     // Charge accumulator copy
  logic [3:0]          ctrl_r;       // Hold, ready, compare, polarity
  logic [15:0]         shunt_high_r; // Shunt high threshold
  logic [5:0]          limit_r;      // Limit flags, bit 7 down to 2
  logic                done_r;       // Conversion done flag
  logic                energy_of_r;  // Energy overflow flag
  logic                charge_of_r;  // Charge overflow flag
  logic                math_of_r;    // Arithmetic overflow flag
  logic                trim_ok_r;    // Trim memory status

  wire hold_sel  = ctrl_r[3];
  wire ready_en  = ctrl_r[2];
  wire cmp_avg   = ctrl_r[1];
  wire polarity  = ctrl_r[0];

  // Result update moment: after averaging when averaging is on
  wire update_evt = (averaging_count == 3'h0) ? sample_valid
                                              : avg_done;  // [R23]
  // Comparison moment: raw or averaged value
  wire cmp_evt = cmp_avg ? avg_done : sample_valid;  // [R9] [R26]

  // ****************************************************************
  // Limit comparisons
  // ****************************************************************
  // Thresholds are 16 times coarser than the 20-bit results, so the
  // top 16 result bits are compared. Power threshold is 256 LSB.
  wire [15:0] shunt_top = shunt_value[19:4];
  wire [15:0] bus_top   = bus_value[19:4];
  wire [15:0] power_top = power_value[23:8];
  wire [5:0]  limit_cond;
  assign limit_cond[5] = sgt(die_temperature_value,
                             temp_high_threshold);  // [R13]
  // Zero already exceeds a negative threshold
  assign limit_cond[4] = sgt(shunt_top, shunt_high_r);  // [R14] [R21]
  assign limit_cond[3] = sgt(shunt_low_threshold, shunt_top);  // [R15]
  assign limit_cond[2] = sgt(bus_top, {1'b0, bus_high_threshold});  // [R16]
  assign limit_cond[1] = sgt({1'b0, bus_low_threshold}, bus_top);  // [R17]
  assign limit_cond[0] = power_top > power_high_threshold;  // [R18]

  // Limit flag next value, set wins over read clear when latched
  wire [5:0] limit_nxt =
    !cmp_evt ? (hold_sel && rd_flags ? 6'h00 : limit_r)
    : hold_sel ? (limit_cond | (rd_flags ? 6'h00 : limit_r))  // [R7]
    : limit_cond;  // [R6]

  // Done flag: set by each update, cleared by read or trigger
  wire done_clr = rd_flags || conversion_trigger;
  wire done_nxt = update_evt || (done_r && !done_clr);  // [R19]

  // Overflow flags, event beats the clearing read or, for arithmetic, trigger or clear
  wire energy_of_nxt = energy_ovf_evt || (energy_of_r && !rd_energy);
  wire charge_of_nxt = charge_ovf_evt || (charge_of_r && !rd_charge);
  wire math_of_nxt = math_ovf_evt || (math_of_r && !conversion_trigger
                     && !accumulator_clear_command);  // [R12]

  // Assembled fault flag register
  wire [15:0] flags_word = {ctrl_r, energy_of_r, charge_of_r, math_of_r,
                            1'b0, limit_r, done_r, trim_ok_r};

  // Alert condition, polarity applied at the pin
  wire alert_active = (|limit_r) || (ready_en && done_r);  // [R8] [R25]

  // ****************************************************************
  // Read data selection
  // ****************************************************************
  wire [39:0] rd_sel =
    (lnk.req_addr == OFS_DIE_TEMPERATURE) ?
      align({24'h00_0000, temp_r}, W_TEMP) :  // [R1]
    (lnk.req_addr == OFS_CURRENT_RESULT) ?
      align({16'h0000, current_r, 4'h0}, W_CURRENT) :  // [R2]
    (lnk.req_addr == OFS_POWER_RESULT) ?
      align({16'h0000, power_r}, W_POWER) :  // [R3]
    (lnk.req_addr == OFS_ENERGY_ACC) ? energy_r :  // [R4]
    (lnk.req_addr == OFS_CHARGE_ACC) ? charge_r :  // [R5]
    (lnk.req_addr == OFS_FAULT_FLAGS) ?
      align({24'h00_0000, flags_word}, W_FLAGS) :
    (lnk.req_addr == OFS_SHUNT_HIGH) ?
      align({24'h00_0000, shunt_high_r}, W_FLAGS) :  // [R24]
    40'h00_0000_0000;

  // ****************************************************************
  // Request handling and link reset
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      req_seen_r <= 1'b0;
      link_rst_r <= 1'b1;
      rd_data_r  <= 40'h00_0000_0000;
    end
    else
    begin
      req_seen_r <= req_s;
      link_rst_r <= 1'b0;
      // Hold read word until the next read
      if (rd_now)
        rd_data_r <= rd_sel;
    end
  end

  // ****************************************************************
  // Results, updated only on completed results
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      temp_r    <= 16'h0000;
      current_r <= 20'h0_0000;
      power_r   <= 24'h00_0000;
      energy_r  <= 40'h00_0000_0000;
      charge_r  <= 40'h00_0000_0000;
    end
    else if (update_evt)  // [R23]
    begin
      temp_r    <= die_temperature_value;  // [R1]
      current_r <= current_value;  // [R2]
      power_r   <= power_value;  // [R3]
      energy_r  <= energy_value;  // [R4]
      charge_r  <= charge_value;  // [R5]
    end
  end

  // ****************************************************************
  // Control and threshold registers
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl_r       <= RST_FAULT_FLAGS[B_HOLD_SEL:B_POLARITY];
      shunt_high_r <= RST_SHUNT_HIGH;
    end
    else
    begin
      // Flag bits of a write are ignored; flags are hardware owned
      if (wr_flags)
        ctrl_r <= lnk.req_wdata[B_HOLD_SEL:B_POLARITY];
      if (wr_shunt)
        shunt_high_r <= lnk.req_wdata;  // [R24]
    end
  end

  // ****************************************************************
  // Flags
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      limit_r     <= RST_FAULT_FLAGS[B_TEMP_OL:B_POWER_OL];
      done_r      <= RST_FAULT_FLAGS[B_CONV_DONE];
      energy_of_r <= RST_FAULT_FLAGS[B_ENERGY_OF];
      charge_of_r <= RST_FAULT_FLAGS[B_CHARGE_OF];
      math_of_r   <= RST_FAULT_FLAGS[B_MATH_OF];
      trim_ok_r   <= RST_FAULT_FLAGS[B_TRIM_OK];  // [R20]
    end
    else
    begin
      limit_r     <= limit_nxt;  // [R6] [R7]
      done_r      <= done_nxt;  // [R19]
      energy_of_r <= energy_of_nxt;  // [R11]
      charge_of_r <= charge_of_nxt;  // [R11]
      math_of_r   <= math_of_nxt;  // [R12]
      // Once an error is seen the status stays low
      if (trim_checksum_err)
        trim_ok_r <= 1'b0;  // [R20]
    end
  end

  // ****************************************************************
  // Alert pin
  // ****************************************************************
  // Open drain: low pulls while active in normal polarity, and while
  // idle in inverted polarity, where the pull-up marks the alert.
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      alert_o  <= 1'b0;
      alert_oe <= 1'b0;
    end
    else
    begin
      alert_o  <= 1'b0;
      alert_oe <= alert_active ^ polarity;  // [R10] [R25]
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_trim_clear: assert property (trim_checksum_err |=> !trim_ok_r) // [R20]
    else $error("trim status not cleared");
  a_trim_stays: assert property (!trim_ok_r |=> !trim_ok_r) // [R20]
    else $error("trim status came back");
  a_alert_level: assert property (##1 alert_oe == // [R10]
      ($past(alert_active) ^ $past(polarity)))
    else $error("alert pin level wrong");
  a_energy_set: assert property (energy_ovf_evt |=> energy_of_r) // [R11]
    else $error("energy overflow not set");
  a_energy_clear: assert property // [R11]
      (rd_energy && !energy_ovf_evt |=> !energy_of_r)
    else $error("energy overflow not cleared");
  a_math_hold: assert property (math_of_r && !conversion_trigger && // [R12]
      !accumulator_clear_command |=> math_of_r)
    else $error("arithmetic overflow lost");
  a_transp_follow: assert property (!hold_sel && cmp_evt |=> // [R6]
      limit_r == $past(limit_cond))
    else $error("transparent flags do not follow");
  a_latch_hold: assert property (hold_sel && !rd_flags && // [R7]
      !cmp_evt ##0 limit_r[5] |=> limit_r[5])
    else $error("latched flag dropped");
  a_done_ready: assert property (ready_en && update_evt && // [R8]
      !polarity ##1 !polarity && ready_en |=> alert_oe)
    else $error("done flag not on alert");
  a_result_take: assert property (update_evt |=> // [R23]
      temp_r == $past(die_temperature_value))
    else $error("result not updated");

  c_latched_read: cover property (hold_sel && limit_r[5] ##1 rd_flags);
  c_alert_done: cover property (ready_en && update_evt ##2 alert_oe);
  c_energy_read: cover property (energy_of_r ##1 rd_energy);
  c_shunt_write: cover property (wr_shunt);

endmodule

// ==== tb/spi_host.sv ====
`timescale 1ns/1ps
// Host end of the serial link: mode 0, MSB first
module spi_host (
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  // Idle: deselected, clock low
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One frame of n bits; the clock stands still between frames
  task automatic xfer(input logic [55:0] tx, input int n,
                      output logic [55:0] rx);
    rx = '0;
    cs_n = 1'b0;
    #40;
    for (int i = 0; i < n; i++)
    begin
      mosi = tx[55-i];
      #40 sclk = 1'b1;
      rx = {rx[54:0], miso};
      #40 sclk = 1'b0;
    end
    // Released line must not keep its last value
    mosi = ~mosi;
    #40 cs_n = 1'b1;
    #200;
  endtask
endmodule

// ==== tb/monitor_results_and_alert_flags_tb_top.sv ====
`timescale 1ns/1ps
// Bench for the result and alert register block
module monitor_results_and_alert_flags_tb_top;
  import monitor_pkg::*;
  logic core_clk, rst, sclk, cs_n, mosi, miso, miso_oe, alert_o, alert_oe;
  logic [7:0]  ev;  // Event strobes, one bit each
  logic [2:0]  averaging_count;
  logic [15:0] die_temperature_value, shunt_low_threshold;
  logic [15:0] temp_high_threshold, power_high_threshold;
  logic [19:0] current_value, shunt_value, bus_value;
  logic [23:0] power_value;
  logic [39:0] energy_value, charge_value;
  logic [14:0] bus_high_threshold, bus_low_threshold;
  int          n_fail, tests_run, cyc;
  monitor_regs u_dut (.energy_ovf_evt(ev[0]), .charge_ovf_evt(ev[1]),
    .math_ovf_evt(ev[2]), .conversion_trigger(ev[3]),
    .accumulator_clear_command(ev[4]), .trim_checksum_err(ev[5]),
    .sample_valid(ev[6]), .avg_done(ev[7]), .*);
  spi_host u_host (.*);
  // Core clock, 25 ns
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Hang guard: far above the expected few thousand cycles
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Read w data bits after command and dummy byte
  task automatic rd(input logic [5:0] a, input int w, input logic [39:0] e);
    logic [55:0] rx;
    u_host.xfer({a, 2'b01, 48'h0}, 16 + w, rx);
    chk(rx[39:0] & ((40'h1 << w) - 40'h1), e);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [55:0] rx;
    u_host.xfer({a, 2'b00, d, 32'h0}, 24, rx);
  endtask
  // Strobe k for one cycle, then let flags and alert settle
  task automatic pulse(input int k);
    @(negedge core_clk) ev[k] = 1'b1;
    @(negedge core_clk) ev[k] = 1'b0;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic t_reset;
    rd(OFS_FAULT_FLAGS, 16, 40'(RST_FAULT_FLAGS));
    rd(OFS_SHUNT_HIGH, 16, 40'(RST_SHUNT_HIGH));
    rd(OFS_DIE_TEMPERATURE, 16, 40'h0);
    // Idle pins: link released, alert data held low
    chk({38'h0, miso_oe, alert_o}, 40'h0);
  endtask
  task automatic t_results;
    @(negedge core_clk);
    die_temperature_value = 16'h8123;
    current_value = 20'h8_0001;
    power_value = 24'hff_0001;
    energy_value = 40'h80_0000_0001;
    charge_value = 40'hff_0000_0002;
    pulse(6);
    rd(OFS_DIE_TEMPERATURE, 16, 40'h8123);
    rd(OFS_CURRENT_RESULT, 24, 40'h80_0010);
    rd(OFS_POWER_RESULT, 24, 40'hff_0001);
    rd(OFS_ENERGY_ACC, 40, 40'h80_0000_0001);
    rd(OFS_CHARGE_ACC, 40, 40'hff_0000_0002);
    @(negedge core_clk);
    averaging_count = 3'h1;
    die_temperature_value = 16'h0042;
    pulse(6);
    rd(OFS_DIE_TEMPERATURE, 16, 40'h8123);
    pulse(7);
    rd(OFS_DIE_TEMPERATURE, 16, 40'h0042);
    @(negedge core_clk);
    averaging_count = 3'h0;
    rd(OFS_FAULT_FLAGS, 16, 40'h0003);
  endtask
  task automatic t_alert;
    @(negedge core_clk);
    temp_high_threshold = 16'h0100;
    die_temperature_value = 16'h0200;
    pulse(6);
    chk(40'(alert_oe), 40'h1);
    rd(OFS_FAULT_FLAGS, 16, 40'h0083);
    @(negedge core_clk);
    die_temperature_value = 16'h0010;
    pulse(6);
    chk(40'(alert_oe), 40'h0);
    wr(OFS_FAULT_FLAGS, 16'h8000);
    @(negedge core_clk);
    die_temperature_value = 16'h0200;
    pulse(6);
    die_temperature_value = 16'h0010;
    pulse(6);
    chk(40'(alert_oe), 40'h1);
    rd(OFS_FAULT_FLAGS, 16, 40'h8083);
    repeat (6) @(negedge core_clk);
    chk(40'(alert_oe), 40'h0);
    wr(OFS_FAULT_FLAGS, 16'h1000);
    repeat (6) @(negedge core_clk);
    chk(40'(alert_oe), 40'h1);
    chk(40'(alert_o), 40'h0);
    wr(OFS_FAULT_FLAGS, 16'h4000);
    pulse(6);
    chk(40'(alert_oe), 40'h1);
  endtask
  task automatic t_ovf;
    pulse(0);
    pulse(1);
    pulse(2);
    // Done flag still set from the last conversion of t_alert
    rd(OFS_FAULT_FLAGS, 16, 40'h4e03);
    rd(OFS_ENERGY_ACC, 40, 40'h80_0000_0001);
    rd(OFS_CHARGE_ACC, 40, 40'hff_0000_0002);
    pulse(3);
    rd(OFS_FAULT_FLAGS, 16, 40'h4001);
  endtask
  task automatic t_shunt;
    // High threshold is the less negative of the two
    wr(OFS_SHUNT_HIGH, 16'h8001);
    rd(OFS_SHUNT_HIGH, 16, 40'h8001);
    pulse(6);
    rd(OFS_FAULT_FLAGS, 16, 40'h4043);
    pulse(2);
    pulse(4);
    pulse(5);
    rd(OFS_FAULT_FLAGS, 16, 40'h4040);
    // Compare on averaged value only: raw strobe leaves limit flags alone
    wr(OFS_FAULT_FLAGS, 16'h2000);
    @(negedge core_clk);
    die_temperature_value = 16'h0200;
    pulse(6);
    rd(OFS_FAULT_FLAGS, 16, 40'h2042);
    pulse(7);
    rd(OFS_FAULT_FLAGS, 16, 40'h20c0);
  endtask
  // Main sequence
  initial
  begin
    {ev, averaging_count, rst, cyc, n_fail, tests_run} = '0;
    {die_temperature_value, current_value, power_value} = '0;
    {shunt_value, bus_value, energy_value, charge_value} = '0;
    {shunt_low_threshold, bus_low_threshold} = {16'h8000, 15'h0};
    {bus_high_threshold, temp_high_threshold} = {15'h7fff, 16'h7fff};
    power_high_threshold = 16'hffff;
    rst = 1'b1;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    t_reset;
    t_results;
    t_alert;
    t_ovf;
    t_shunt;
    end_sim;
  end
endmodule
